/* File: logic/phy_mode_cfg.svh */
`ifndef PHY_MODE_CFG_SVH
`define PHY_MODE_CFG_SVH

// Register indices, byte address is four times the index
`define PWR_STATUS_IDX        8'h11
`define MODE_ADDR_IDX         8'h12
`define IDX_TO_BYTE_SHIFT     2

// Power and energy status fields
`define EDPD_EN_BIT           13
`define ENERGY_BIT            1
`define PWR_SPARE_BIT         0

// Operating mode and address fields
`define MODE_MSB              7
`define MODE_LSB              5
`define ADDR_MSB              4
`define ADDR_LSB              0

// Reset values
`define EDPD_EN_RST           1'b0
`define ENERGY_RST            1'b1
`define PWR_SPARE_RST         1'b0
`define MODE_ALL_CAPABLE      3'h7
`define MODE_RST              3'h0
`define ADDR_RST              5'h00

// Energy quiet time and clock rate
`define ENERGY_QUIET_MS       256
`define CLK_KHZ               100000

`endif

/* File: logic/phy_mode_pkg.sv */
package phy_mode_pkg;

   typedef enum logic [2:0] {
      MODE_10_HALF     = 3'h0,
      MODE_10_FULL     = 3'h1,
      MODE_100_HALF    = 3'h2,
      MODE_100_FULL    = 3'h3,
      MODE_AN_100_HALF = 3'h4,
      MODE_REPEATER    = 3'h5,
      MODE_POWER_DOWN  = 3'h6,
      MODE_ALL_CAPABLE = 3'h7
   } phy_mode_t;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ANSWER,
      BUS_DONE
   } bus_state_t;

endpackage : phy_mode_pkg

/* File: logic/energy_watch.sv */
`timescale 1ns/1ps
`include "phy_mode_cfg.svh"

module energy_watch #(
   parameter int unsigned QUIET_CYCLES = 25600000
) (
   input  wire logic mclk_i,
   input  wire logic reset_i,
   input  wire logic ce_i,
   input  wire logic line_energy_i,
   output logic      line_energy_present_o
);

   localparam int unsigned CNT_W = $clog2(QUIET_CYCLES + 1);

   logic [CNT_W-1:0] quiet_cnt_ff;
   logic             present_ff;

   // Quiet-time counter, restarted by any energy on the line
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         quiet_cnt_ff <= '0;
      else if (ce_i)
      begin
         if (line_energy_i)
            quiet_cnt_ff <= '0;
         else if (quiet_cnt_ff != CNT_W'(QUIET_CYCLES))
            quiet_cnt_ff <= quiet_cnt_ff + CNT_W'(1);
      end
   end

   // Of the resets, only hardware reset touches the flag, soft resets never reach here
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         present_ff <= `ENERGY_RST;
      else if (ce_i)
      begin
         if (line_energy_i)
            present_ff <= 1'b1;
         else if (quiet_cnt_ff == CNT_W'(QUIET_CYCLES - 1))
            present_ff <= 1'b0;
      end
   end

   assign line_energy_present_o = present_ff;

endmodule : energy_watch

/* File: logic/mode_decode.sv */
`timescale 1ns/1ps

module mode_decode (
   input  wire logic [2:0] mode_i,
   output logic      [3:0] basic_ctrl_bits_o,
   output logic      [3:0] advert_bits_o,
   output logic            advert_valid_o,
   output logic            crs_on_transmit_o,
   output logic            repeater_o,
   output logic            power_down_o
);

   // Bit order of basic_ctrl_bits_o: speed, negotiation enable, unused (power down has its own output), duplex
   always_comb
   begin
      basic_ctrl_bits_o = 4'h0;
      advert_bits_o     = 4'h0;
      advert_valid_o    = 1'b0;
      crs_on_transmit_o = 1'b0;
      repeater_o        = 1'b0;
      power_down_o      = 1'b0;
      case (phy_mode_pkg::phy_mode_t'(mode_i))
         phy_mode_pkg::MODE_10_HALF:
            basic_ctrl_bits_o = 4'h0;
         phy_mode_pkg::MODE_10_FULL:
            basic_ctrl_bits_o = 4'h1;
         phy_mode_pkg::MODE_100_HALF:
         begin
            basic_ctrl_bits_o = 4'h8;
            crs_on_transmit_o = 1'b1;
         end
         phy_mode_pkg::MODE_100_FULL:
            basic_ctrl_bits_o = 4'h9;
         phy_mode_pkg::MODE_AN_100_HALF:
         begin
            basic_ctrl_bits_o = 4'hc;
            advert_bits_o     = 4'h4;
            advert_valid_o    = 1'b1;
            crs_on_transmit_o = 1'b1;
         end
         phy_mode_pkg::MODE_REPEATER:
         begin
            basic_ctrl_bits_o = 4'hc;
            advert_bits_o     = 4'h4;
            advert_valid_o    = 1'b1;
            repeater_o        = 1'b1;
         end
         phy_mode_pkg::MODE_POWER_DOWN:
            power_down_o = 1'b1;
         phy_mode_pkg::MODE_ALL_CAPABLE:
         begin
            // Speed and duplex are free here; chosen as the fastest pair
            basic_ctrl_bits_o = 4'hd;
            advert_bits_o     = 4'hf;
            advert_valid_o    = 1'b1;
         end
         default:
            basic_ctrl_bits_o = 4'h0;
      endcase
   end

endmodule : mode_decode

/* File: logic/phy_mode_config_regs.sv */
`timescale 1ns/1ps
`include "phy_mode_cfg.svh"

module phy_mode_config_regs #(
   parameter int unsigned ADDR_W       = 8,
   parameter int unsigned QUIET_CYCLES = `ENERGY_QUIET_MS * `CLK_KHZ
) (
   input  wire logic              mclk_i,
   input  wire logic              reset_i,
   input  wire logic              ce_i,
   // APB slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Configuration straps
   input  wire logic              autoneg_strap_i,
   input  wire logic              speed_strap_i,
   input  wire logic              duplex_strap_i,
   input  wire logic [4:0]        addr_sel_strap_i,
   // Reset sources
   input  wire logic              port_phy_reset_i,
   input  wire logic              basic_ctrl_reset_i,
   // EEPROM loader write
   input  wire logic              eeprom_load_i,
   input  wire logic [15:0]       eeprom_data_i,
   // Line and management port
   input  wire logic              line_energy_i,
   input  wire logic              mgmt_access_i,
   input  wire logic [4:0]        mgmt_target_addr_i,
   output logic                   mgmt_address_hit_o,
   // PHY controls
   output logic                   energy_detect_powerdown_enable_o,
   output logic                   line_energy_present_o,
   output logic      [2:0]        operating_mode_o,
   output logic      [4:0]        management_address_o,
   output logic      [4:0]        scrambler_seed_o,
   output logic      [3:0]        basic_ctrl_bits_o,
   output logic      [3:0]        negotiation_advertisement_o,
   output logic                   advert_valid_o,
   output logic                   crs_on_transmit_o,
   output logic                   repeater_o,
   output logic                   power_down_o
);

   localparam logic [ADDR_W-1:0] PWR_ADDR  = ADDR_W'(`PWR_STATUS_IDX) << `IDX_TO_BYTE_SHIFT;
   localparam logic [ADDR_W-1:0] MODE_ADDR = ADDR_W'(`MODE_ADDR_IDX) << `IDX_TO_BYTE_SHIFT;

   phy_mode_pkg::bus_state_t bus_state_ff;
   phy_mode_pkg::bus_state_t nxt_bus_state;

   logic        straps_taken_ff;
   logic        autoneg_latch_ff;
   logic        speed_latch_ff;
   logic        duplex_latch_ff;
   logic [4:0]  addr_latch_ff;

   logic        edpd_en_ff;
   logic        pwr_spare_ff;
   logic [2:0]  mode_ff;
   logic [4:0]  addr_ff;

   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        hit_ff;

   logic [3:0]  ctrl_bits_ff;
   logic [3:0]  adv_bits_ff;
   logic        adv_valid_ff;
   logic        crs_tx_ff;
   logic        repeater_ff;
   logic        pdown_ff;

   logic        energy_present;
   logic [3:0]  dec_ctrl_bits;
   logic [3:0]  dec_adv_bits;
   logic        dec_adv_valid;
   logic        dec_crs_tx;
   logic        dec_repeater;
   logic        dec_pdown;

   logic        bus_commit;
   logic        bus_write;
   logic [2:0]  mode_default;

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      addr_mapped = (a == PWR_ADDR) || (a == MODE_ADDR);
   endfunction : addr_mapped

   function automatic logic [15:0] read_word(input logic [ADDR_W-1:0] a,
                                             input logic              edpd,
                                             input logic              energy,
                                             input logic              spare,
                                             input logic [2:0]        mode,
                                             input logic [4:0]        addr);
      read_word = 16'h0000;
      if (a == PWR_ADDR)
      begin
         read_word[`EDPD_EN_BIT]   = edpd;
         read_word[`ENERGY_BIT]    = energy;
         read_word[`PWR_SPARE_BIT] = spare;
      end
      else if (a == MODE_ADDR)
      begin
         read_word[`MODE_MSB:`MODE_LSB] = mode;
         read_word[`ADDR_MSB:`ADDR_LSB] = addr;
      end
   endfunction : read_word

   // Strap-derived mode default
   always_comb
   begin
      if (autoneg_latch_ff)
         mode_default = `MODE_ALL_CAPABLE;
      else
         mode_default = {1'b0, speed_latch_ff, duplex_latch_ff};
   end

   // Bus phases: one wait cycle, then the answer
   always_comb
   begin
      nxt_bus_state = bus_state_ff;
      case (bus_state_ff)
         phy_mode_pkg::BUS_IDLE:
            if (psel_i && penable_i)
               nxt_bus_state = phy_mode_pkg::BUS_ANSWER;
         phy_mode_pkg::BUS_ANSWER:
            nxt_bus_state = phy_mode_pkg::BUS_DONE;
         phy_mode_pkg::BUS_DONE:
            nxt_bus_state = phy_mode_pkg::BUS_IDLE;
         default:
            nxt_bus_state = phy_mode_pkg::BUS_IDLE;
      endcase
   end

   assign bus_commit = (bus_state_ff == phy_mode_pkg::BUS_ANSWER);
   assign bus_write  = bus_commit && pwrite_i && addr_mapped(paddr_i);

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         bus_state_ff <= phy_mode_pkg::BUS_IDLE;
      else if (ce_i)
         bus_state_ff <= nxt_bus_state;
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         pready_ff  <= (nxt_bus_state == phy_mode_pkg::BUS_ANSWER);
         pslverr_ff <= (nxt_bus_state == phy_mode_pkg::BUS_ANSWER) && !addr_mapped(paddr_i);
         if (nxt_bus_state == phy_mode_pkg::BUS_ANSWER && !pwrite_i)
            prdata_ff <= {16'h0000, read_word(paddr_i, edpd_en_ff, energy_present,
                                               pwr_spare_ff, mode_ff, addr_ff)};
         else
            prdata_ff <= 32'h0000_0000;
      end
   end

   // Straps taken on the first enabled cycle after chip reset releases
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         straps_taken_ff  <= 1'b0;
         autoneg_latch_ff <= 1'b0;
         speed_latch_ff   <= 1'b0;
         duplex_latch_ff  <= 1'b0;
         addr_latch_ff    <= `ADDR_RST;
      end
      else if (ce_i && !straps_taken_ff)
      begin
         straps_taken_ff  <= 1'b1;
         autoneg_latch_ff <= autoneg_strap_i;
         speed_latch_ff   <= speed_strap_i;
         duplex_latch_ff  <= duplex_strap_i;
         addr_latch_ff    <= addr_sel_strap_i;
      end
   end

   // Power control: port reset and soft reset both restore it
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         edpd_en_ff   <= `EDPD_EN_RST;
         pwr_spare_ff <= `PWR_SPARE_RST;
      end
      else if (ce_i)
      begin
         if (port_phy_reset_i || basic_ctrl_reset_i)
         begin
            edpd_en_ff   <= `EDPD_EN_RST;
            pwr_spare_ff <= `PWR_SPARE_RST;
         end
         else if (bus_write && paddr_i == PWR_ADDR)
         begin
            edpd_en_ff   <= pwdata_i[`EDPD_EN_BIT];
            pwr_spare_ff <= pwdata_i[`PWR_SPARE_BIT];
         end
      end
   end

   // Mode field: port reset restores it, own soft reset does not
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         mode_ff <= `MODE_RST;
      else if (ce_i)
      begin
         if (!straps_taken_ff)
         begin
            if (autoneg_strap_i)
               mode_ff <= `MODE_ALL_CAPABLE;
            else
               mode_ff <= {1'b0, speed_strap_i, duplex_strap_i};
         end
         else if (port_phy_reset_i)
            mode_ff <= mode_default;
         else if (eeprom_load_i)
            mode_ff <= eeprom_data_i[`MODE_MSB:`MODE_LSB];
         else if (bus_write && paddr_i == MODE_ADDR)
            mode_ff <= pwdata_i[`MODE_MSB:`MODE_LSB];
      end
   end

   // Management address: only chip reset, the strap latch and writers change it
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         addr_ff <= `ADDR_RST;
      else if (ce_i)
      begin
         if (!straps_taken_ff)
            addr_ff <= addr_sel_strap_i;
         else if (eeprom_load_i)
            addr_ff <= eeprom_data_i[`ADDR_MSB:`ADDR_LSB];
         else if (bus_write && paddr_i == MODE_ADDR)
            addr_ff <= pwdata_i[`ADDR_MSB:`ADDR_LSB];
      end
   end

   // Duplicate addresses among PHYs go undetected here
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         hit_ff <= 1'b0;
      else if (ce_i)
         hit_ff <= mgmt_access_i && straps_taken_ff && (mgmt_target_addr_i == addr_ff);
   end

   mode_decode u_mode_decode (
      .mode_i            (mode_ff),
      .basic_ctrl_bits_o (dec_ctrl_bits),
      .advert_bits_o     (dec_adv_bits),
      .advert_valid_o    (dec_adv_valid),
      .crs_on_transmit_o (dec_crs_tx),
      .repeater_o        (dec_repeater),
      .power_down_o      (dec_pdown)
   );

   // Registered so the PHY sees glitch-free controls
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         ctrl_bits_ff <= 4'h0;
         adv_bits_ff  <= 4'h0;
         adv_valid_ff <= 1'b0;
         crs_tx_ff    <= 1'b0;
         repeater_ff  <= 1'b0;
         pdown_ff     <= 1'b0;
      end
      else if (ce_i)
      begin
         ctrl_bits_ff <= dec_ctrl_bits;
         adv_bits_ff  <= dec_adv_bits;
         adv_valid_ff <= dec_adv_valid;
         crs_tx_ff    <= dec_crs_tx;
         repeater_ff  <= dec_repeater;
         pdown_ff     <= dec_pdown;
      end
   end

   energy_watch #(
      .QUIET_CYCLES (QUIET_CYCLES)
   ) u_energy_watch (
      .mclk_i                (mclk_i),
      .reset_i               (reset_i),
      .ce_i                  (ce_i),
      .line_energy_i         (line_energy_i),
      .line_energy_present_o (energy_present)
   );

   assign prdata_o                         = prdata_ff;
   assign pready_o                         = pready_ff;
   assign pslverr_o                        = pslverr_ff;
   assign mgmt_address_hit_o               = hit_ff;
   assign energy_detect_powerdown_enable_o = edpd_en_ff;
   assign line_energy_present_o            = energy_present;
   assign operating_mode_o                 = mode_ff;
   assign management_address_o             = addr_ff;
   assign scrambler_seed_o                 = addr_ff;
   assign basic_ctrl_bits_o                = ctrl_bits_ff;
   assign negotiation_advertisement_o      = adv_bits_ff;
   assign advert_valid_o                   = adv_valid_ff;
   assign crs_on_transmit_o                = crs_tx_ff;
   assign repeater_o                       = repeater_ff;
   assign power_down_o                     = pdown_ff;

endmodule : phy_mode_config_regs

/* File: verification/phy_mode_checker_assertions.sv */
`timescale 1ns/1ps
`include "phy_mode_cfg.svh"
module phy_mode_checker #(
   parameter int unsigned ADDR_W       = 8,
   parameter int unsigned QUIET_CYCLES = 16
) (
   input wire logic              mclk_i,
   input wire logic              reset_i,
   input wire logic              ce_i,
   input wire logic              pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0]       pwdata_i,
   input wire logic [31:0]       prdata_o,
   input wire logic              pready_o,
   input wire logic              port_phy_reset_i,
   input wire logic              eeprom_load_i,
   input wire logic [15:0]       eeprom_data_i,
   input wire logic              line_energy_i,
   input wire logic              mgmt_access_i,
   input wire logic [4:0]        mgmt_target_addr_i,
   input wire logic              mgmt_address_hit_o,
   input wire logic              energy_detect_powerdown_enable_o,
   input wire logic              line_energy_present_o,
   input wire logic [2:0]        operating_mode_o,
   input wire logic [4:0]        management_address_o,
   input wire logic [4:0]        scrambler_seed_o,
   input wire logic [3:0]        basic_ctrl_bits_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);
   int unsigned quiet_ff;
   logic        at_pwr;
   logic        at_mode;
   assign at_pwr  = paddr_i == ADDR_W'(`PWR_STATUS_IDX << `IDX_TO_BYTE_SHIFT);
   assign at_mode = paddr_i == ADDR_W'(`MODE_ADDR_IDX << `IDX_TO_BYTE_SHIFT);
   // Saturates so a long quiet line never wraps to zero
   always_ff @(posedge mclk_i)
   begin
      if (reset_i || line_energy_i)
         quiet_ff <= 0;
      else if (ce_i && quiet_ff < QUIET_CYCLES + 8)
         quiet_ff <= quiet_ff + 1;
   end
   function automatic logic [3:0] basic_of(input logic [2:0] m);
      return 4'(32'hd0cc9810 >> {m, 2'b00});
   endfunction : basic_of
   property p_basic;
      !$past(reset_i) |-> basic_ctrl_bits_o == basic_of($past(operating_mode_o));
   endproperty
   a_basic: assert property (p_basic) else $error("basic bits off");
   property p_edpd_write;
      pready_o && pwrite_i && at_pwr && !port_phy_reset_i
         |=> energy_detect_powerdown_enable_o == |($past(pwdata_i) & 32'h2000);
   endproperty
   a_edpd_write: assert property (p_edpd_write) else $error("powerdown enable not written");
   property p_mode_write;
      pready_o && pwrite_i && at_mode && !eeprom_load_i && !port_phy_reset_i
         |=> {operating_mode_o, management_address_o} == 8'($past(pwdata_i));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode field not written");
   property p_eeprom;
      eeprom_load_i && ce_i && !port_phy_reset_i && !$past(reset_i)
         |=> {operating_mode_o, management_address_o} == 8'($past(eeprom_data_i));
   endproperty
   a_eeprom: assert property (p_eeprom) else $error("loader data not taken");
   property p_port_reset;
      port_phy_reset_i && ce_i |=> !energy_detect_powerdown_enable_o;
   endproperty
   a_port_reset: assert property (p_port_reset) else $error("port reset kept enable");
   property p_energy_hw;
      disable iff (1'b0) reset_i && ce_i |=> line_energy_present_o;
   endproperty
   a_energy_hw: assert property (p_energy_hw) else $error("energy flag not set by reset");
   property p_energy_quiet;
      quiet_ff >= QUIET_CYCLES + 3 |-> !line_energy_present_o;
   endproperty
   a_energy_quiet: assert property (p_energy_quiet) else $error("energy flag outlived quiet time");
   property p_hit;
      !$past(reset_i) && !$past(reset_i, 2) |-> mgmt_address_hit_o ==
         ($past(mgmt_access_i) && $past(mgmt_target_addr_i) == $past(management_address_o));
   endproperty
   a_hit: assert property (p_hit) else $error("address match wrong");
   // Seed must follow a written address, not merely mirror the field
   property p_seed;
      pready_o && pwrite_i && at_mode && !eeprom_load_i |=> scrambler_seed_o == 5'($past(pwdata_i));
   endproperty
   a_seed: assert property (p_seed) else $error("seed differs from address");
   property p_reserved;
      pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0 && (!at_pwr || (prdata_o & 32'hdffc) == 32'h0)
         && (!at_mode || prdata_o[15:8] == 8'h0);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule : phy_mode_checker
bind phy_mode_config_regs phy_mode_checker #(.ADDR_W(ADDR_W), .QUIET_CYCLES(QUIET_CYCLES)) phy_mode_checker_i (.*);

/* File: verification/mgmt_host_model.sv */
`timescale 1ns/1ps
module mgmt_host_model (
   input  wire logic       mclk_i,
   input  wire logic       probe_i,
   input  wire logic [4:0] probe_addr_i,
   output logic            mgmt_access_o = 1'b0,
   output logic      [4:0] mgmt_target_addr_o = 5'h00
);
   // Each probe drives the address it is given, whether or not the port owns it
   always @(posedge mclk_i)
   begin
      mgmt_access_o <= probe_i;
      // Idle lines toggle so a stale address never looks valid
      mgmt_target_addr_o <= probe_i ? probe_addr_i : ~mgmt_target_addr_o;
   end
endmodule : mgmt_host_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`include "phy_mode_cfg.svh"
module testbench;
   localparam int unsigned QUIET  = 16;
   localparam logic [7:0]  A_PWR  = 8'(`PWR_STATUS_IDX << `IDX_TO_BYTE_SHIFT);
   localparam logic [7:0]  A_MODE = 8'(`MODE_ADDR_IDX << `IDX_TO_BYTE_SHIFT);
   logic        mclk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic        autoneg_strap_i = 1'b1, speed_strap_i = 1'b0, duplex_strap_i = 1'b0, probe = 1'b0;
   logic        port_phy_reset_i = 1'b0, basic_ctrl_reset_i = 1'b0, eeprom_load_i = 1'b0, line_energy_i = 1'b1;
   logic        mgmt_access_i, mgmt_address_hit_o, pready_o, pslverr_o, advert_valid_o;
   logic        energy_detect_powerdown_enable_o, line_energy_present_o, crs_on_transmit_o, repeater_o, power_down_o;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic [15:0] eeprom_data_i = 16'h0;
   logic [4:0]  addr_sel_strap_i = 5'h0a, probe_addr = 5'h00, mgmt_target_addr_i, management_address_o, scrambler_seed_o;
   logic [2:0]  operating_mode_o;
   logic [3:0]  basic_ctrl_bits_o, negotiation_advertisement_o;
   int          mismatches = 0, comparisons = 0;
   phy_mode_config_regs #(.QUIET_CYCLES(QUIET)) phy_mode_config_regs_i (.*);
   mgmt_host_model mgmt_host_model_i (
      .mclk_i            (mclk_i),
      .probe_i           (probe),
      .probe_addr_i      (probe_addr),
      .mgmt_access_o     (mgmt_access_i),
      .mgmt_target_addr_o(mgmt_target_addr_i)
   );
   always #5 mclk_i = ~mclk_i;
   task automatic tally_and_finish();
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Sampled at the edge itself, before that edge's updates land
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 20)
      begin
         mismatches++;
         tally_and_finish();
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp);
      check(32'(e), 32'(exp_err));
   endtask : rd
   task automatic probe_at(input logic [4:0] a, input logic exp);
      @(posedge mclk_i);
      probe <= 1'b1;
      probe_addr <= a;
      @(posedge mclk_i);
      probe <= 1'b0;
      @(posedge mclk_i);
      #1;
      check(32'(mgmt_address_hit_o), 32'(exp));
   endtask : probe_at
   initial
   begin
      logic [11:0] exp;
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      // Straps move after the latch and must not matter
      autoneg_strap_i <= 1'b0;
      rd(A_MODE, 32'hea, 1'b0);
      rd(A_PWR, 32'h2, 1'b0);
      wr(A_PWR, 32'hffffffff);
      rd(A_PWR, 32'h2003, 1'b0);
      for (int m = 0; m < 8; m++)
      begin
         wr(A_MODE, {24'hffffff, 3'(m), 5'h0a});
         repeat (2) @(posedge mclk_i);
         #1;
         exp = {4'(32'hd0cc9810 >> (4 * m)), 4'(32'h81ac0400 >> (4 * m)), 4'(32'hf0440000 >> (4 * m))};
         check(32'({basic_ctrl_bits_o, advert_valid_o, crs_on_transmit_o, repeater_o, power_down_o,
                    negotiation_advertisement_o & {4{advert_valid_o}}}), 32'(exp));
         rd(A_MODE, {24'h0, 3'(m), 5'h0a}, 1'b0);
      end
      probe_at(5'h0a, 1'b1);
      probe_at(5'h0b, 1'b0);
      check(32'(scrambler_seed_o), 32'h0a);
      rd(8'h4c, 32'h0, 1'b1);
      @(posedge mclk_i);
      eeprom_load_i <= 1'b1;
      eeprom_data_i <= 16'h0053;
      @(posedge mclk_i);
      eeprom_load_i <= 1'b0;
      #1;
      check(32'({operating_mode_o, management_address_o}), 32'h53);
      wr(A_PWR, 32'h2001);
      @(posedge mclk_i);
      port_phy_reset_i <= 1'b1;
      @(posedge mclk_i);
      port_phy_reset_i <= 1'b0;
      rd(A_PWR, 32'h2, 1'b0);
      rd(A_MODE, 32'hf3, 1'b0);
      wr(A_MODE, 32'h63);
      @(posedge mclk_i);
      basic_ctrl_reset_i <= 1'b1;
      @(posedge mclk_i);
      basic_ctrl_reset_i <= 1'b0;
      rd(A_MODE, 32'h63, 1'b0);
      line_energy_i <= 1'b0;
      repeat (QUIET + 4) @(posedge mclk_i);
      #1;
      check(32'(line_energy_present_o), 32'h0);
      @(posedge mclk_i);
      line_energy_i <= 1'b1;
      @(posedge mclk_i);
      line_energy_i <= 1'b0;
      #1;
      check(32'(line_energy_present_o), 32'h1);
      repeat (QUIET + 4) @(posedge mclk_i);
      basic_ctrl_reset_i <= 1'b1;
      @(posedge mclk_i);
      basic_ctrl_reset_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      check(32'(line_energy_present_o), 32'h0);
      @(posedge mclk_i);
      speed_strap_i <= 1'b1;
      addr_sel_strap_i <= 5'h07;
      reset_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      check(32'(line_energy_present_o), 32'h1);
      rd(A_MODE, 32'h47, 1'b0);
      // Clock enable low must freeze the register against a loader write
      ce_i <= 1'b0;
      eeprom_load_i <= 1'b1;
      eeprom_data_i <= 16'h00e1;
      repeat (3) @(posedge mclk_i);
      #1;
      check(32'({operating_mode_o, management_address_o}), 32'h47);
      @(posedge mclk_i);
      ce_i <= 1'b1;
      eeprom_load_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      check(32'({operating_mode_o, management_address_o}), 32'h47);
      tally_and_finish();
   end
endmodule : testbench
